// *** src/lms_line_sublayer.sv ***
// Handshake logic at the boundary of the line modulation sublayer.
// Assumes all partners run on clk; the line side drains a buffered stream.
`timescale 1ns/1ps
`default_nettype none
`include "lms_defs.svh"

module lms_line_sublayer #(
  parameter int SYM_CYCLES = `LMS_SYM_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Transmit framing sublayer: payload frames
  output logic                          symbol_data_xfer_req,
  input  wire logic                     symbol_data_xfer_cfm,
  input  wire logic [`LMS_FRAME_W-1:0]  symbol_data_xfer_bits,
  output logic [`LMS_LEN_W-1:0]         symbol_data_xfer_len,
  // Transmit framing sublayer: sync flag
  input  wire logic                     sync_flag_xfer_req,
  output logic                          sync_flag_xfer_cfm,
  // Line side transmit stream
  output logic                          tx_sym_valid,
  input  wire logic                     tx_sym_ready,
  output logic [`LMS_FRAME_W-1:0]       tx_sym_data,
  output logic [`LMS_KIND_W-1:0]        tx_sym_kind,
  // Line side receive stream
  input  wire logic                     rx_sym_valid,
  input  wire logic [`LMS_KIND_W-1:0]   rx_sym_kind,
  input  wire logic [`LMS_FRAME_W-1:0]  rx_sym_data,
  // Receive framing sublayer
  output logic                          symbol_data_xfer_ind,
  output logic [`LMS_FRAME_W-1:0]       symbol_data_xfer_ind_bits,
  output logic                          sync_flag_xfer_ind,
  // Near-end control functions
  input  wire logic                     param_change_notice,
  input  wire logic                     rx_reconfig_need,
  output logic                          far_param_change_xfer_req,
  output logic [1:0]                    far_param_change_xfer_cause,
  input  wire logic                     far_param_change_xfer_cfm,
  input  wire logic                     far_param_change_xfer_ind,
  input  wire logic [`LMS_LEN_W-1:0]    far_param_change_xfer_len,
  // Status
  output logic [`LMS_POS_W-1:0]         superframe_pos,
  output logic                          sync_flag_busy
);

  localparam int BUF_W = `LMS_FRAME_W + `LMS_KIND_W;

  // -----------------------------------------------------------------
  // Symbol-rate divider
  // -----------------------------------------------------------------
  logic [15:0] div_r;
  wire         sym_tick = (div_r == 16'(SYM_CYCLES - 1));

  // One enable pulse per symbol period at the framing-side rate.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= sym_tick ? 16'h0000 : div_r + 16'h0001;
    end
  end

  // -----------------------------------------------------------------
  // Transmit buffer toward the line
  // -----------------------------------------------------------------
  logic             buf_in_valid;
  logic             buf_in_ready;
  logic [BUF_W-1:0] buf_in_data;
  logic             buf_out_valid;
  logic [BUF_W-1:0] buf_out_data;
  logic [1:0]       buf_count;

  lms_pair_buf #(
    .W (BUF_W)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (tx_sym_ready),
    .out_data  (buf_out_data),
    .count     (buf_count)
  );

  assign tx_sym_valid = buf_out_valid;
  assign tx_sym_kind  = buf_out_data[BUF_W-1 -: `LMS_KIND_W];
  assign tx_sym_data  = buf_out_data[`LMS_FRAME_W-1:0];

  // -----------------------------------------------------------------
  // Transmit sequencer state
  // -----------------------------------------------------------------
  lms_pkg::lms_tx_state_t   tx_state_r;
  lms_pkg::lms_tx_state_t   tx_state_nxt;
  logic                     tick_pend_r;
  logic [`LMS_POS_W-1:0]    pos_r;
  logic                     flag_pend_r;
  logic                     flag_sent_r;
  logic                     flag_cfm_r;
  logic [`LMS_LEN_W-1:0]    len_r;
  logic [`LMS_LEN_W-1:0]    len_pend_r;
  logic                     len_upd_r;

  // Free slots decide who may claim the buffer this cycle.
  wire free_two  = (buf_count == 2'h0);
  wire free_one  = (buf_count != 2'h2);
  wire in_wait   = (tx_state_r == lms_pkg::LMS_TX_WAIT);
  wire in_req    = (tx_state_r == lms_pkg::LMS_TX_REQ);
  wire in_sync   = (tx_state_r == lms_pkg::LMS_TX_SYNC);
  wire last_data = (pos_r == 7'(`LMS_SF_DATA_SYMS - 1));

  // A flag may jump ahead of an outstanding frame only if a slot stays reserved
  // for that frame's confirm, so no confirmed word is ever refused.
  wire flag_push = flag_pend_r & ~in_sync & ~symbol_data_xfer_cfm &
                   (in_wait ? free_two : free_one);
  wire sync_push = in_sync & buf_in_ready;
  wire data_push = in_wait & symbol_data_xfer_cfm;
  wire can_req   = in_req & (free_two | (free_one & ~flag_push));
  wire flag_pop  = buf_out_valid & tx_sym_ready &
                   (tx_sym_kind == `LMS_KIND_W'(lms_pkg::LMS_KIND_FLAG));

  // One strobe per data symbol, issued only when the confirm has room.
  assign symbol_data_xfer_req = can_req;
  assign symbol_data_xfer_len = len_r;
  assign sync_flag_xfer_cfm   = flag_cfm_r;
  assign sync_flag_busy       = flag_pend_r | flag_sent_r;
  assign superframe_pos       = pos_r;

  // Buffer write mux: confirmed data first, then sync symbol, then flag.
  assign buf_in_valid = data_push | sync_push | flag_push;
  assign buf_in_data  =
    data_push ? {`LMS_KIND_W'(lms_pkg::LMS_KIND_DATA), symbol_data_xfer_bits} :
    sync_push ? {`LMS_KIND_W'(lms_pkg::LMS_KIND_SYNC), `LMS_FRAME_W'(0)} :
                {`LMS_KIND_W'(lms_pkg::LMS_KIND_FLAG), `LMS_FRAME_W'(0)};

  // Sequencer: tick, request, wait confirm, and after symbol 67 a sync symbol.
  always_comb begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      lms_pkg::LMS_TX_IDLE: begin
        if (tick_pend_r) begin
          tx_state_nxt = lms_pkg::LMS_TX_REQ;
        end
      end
      lms_pkg::LMS_TX_REQ: begin
        if (can_req) begin
          tx_state_nxt = lms_pkg::LMS_TX_WAIT;
        end
      end
      lms_pkg::LMS_TX_WAIT: begin
        if (data_push) begin
          tx_state_nxt = last_data ? lms_pkg::LMS_TX_SYNC
                                   : lms_pkg::LMS_TX_IDLE;
        end
      end
      lms_pkg::LMS_TX_SYNC: begin
        if (sync_push) begin
          tx_state_nxt = lms_pkg::LMS_TX_IDLE;
        end
      end
      default: begin
        tx_state_nxt = lms_pkg::LMS_TX_IDLE;
      end
    endcase
  end

  // State, pending tick and superframe position.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_state_r  <= lms_pkg::LMS_TX_IDLE;
      tick_pend_r <= 1'b0;
      pos_r       <= '0;
    end else begin
      tx_state_r  <= tx_state_nxt;
      // A tick landing as the old one is consumed is kept.
      tick_pend_r <= sym_tick | (tick_pend_r & ~(in_req & can_req));
      if (data_push) begin
        pos_r <= last_data ? '0 : pos_r + 7'h01;
      end
    end
  end

  // Flag life: pending until queued, sent until the line takes it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_pend_r <= 1'b0;
      flag_sent_r <= 1'b0;
      flag_cfm_r  <= 1'b0;
    end else begin
      flag_pend_r <= sync_flag_xfer_req | (flag_pend_r & ~flag_push);
      flag_sent_r <= flag_push | (flag_sent_r & ~flag_pop);
      flag_cfm_r  <= flag_pop;
    end
  end

  // New transmit length is taken at the next symbol tick, whatever the sequencer state, so also while a frame awaits its confirm.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      len_r      <= `LMS_LEN_RST;
      len_pend_r <= `LMS_LEN_RST;
      len_upd_r  <= 1'b0;
    end else begin
      if (far_param_change_xfer_ind) begin
        len_pend_r <= far_param_change_xfer_len;
      end
      len_upd_r <= far_param_change_xfer_ind | (len_upd_r & ~sym_tick);
      if (len_upd_r && sym_tick) begin
        len_r <= len_pend_r;
      end
    end
  end

  // -----------------------------------------------------------------
  // Receive path toward the framing sublayer
  // -----------------------------------------------------------------
  wire rx_is_data = rx_sym_valid &
                    (rx_sym_kind == `LMS_KIND_W'(lms_pkg::LMS_KIND_DATA));
  wire rx_is_flag = rx_sym_valid &
                    (rx_sym_kind == `LMS_KIND_W'(lms_pkg::LMS_KIND_FLAG));

  // One symbol per cycle in, one indication per cycle out, so the flag
  // indication falls between the frames exactly as on the line.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      symbol_data_xfer_ind      <= 1'b0;
      symbol_data_xfer_ind_bits <= '0;
      sync_flag_xfer_ind        <= 1'b0;
    end else begin
      symbol_data_xfer_ind <= rx_is_data;
      sync_flag_xfer_ind   <= rx_is_flag;
      if (rx_is_data) begin
        symbol_data_xfer_ind_bits <= rx_sym_data;
      end
    end
  end

  // -----------------------------------------------------------------
  // Control requests toward the near-end control functions
  // -----------------------------------------------------------------
  logic notice_pend_r;
  logic need_pend_r;
  logic ctl_busy_r;
  logic ctl_req_r;
  logic [1:0] ctl_cause_r;

  // Only one request outstanding; the notice wins over the receive need.
  wire ctl_issue   = ~ctl_busy_r & (notice_pend_r | need_pend_r);
  wire issue_notic = ctl_issue & notice_pend_r;
  wire issue_need  = ctl_issue & ~notice_pend_r;

  assign far_param_change_xfer_req   = ctl_req_r;
  assign far_param_change_xfer_cause = ctl_cause_r;

  // Pending causes: a new event in the issue cycle survives the clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      notice_pend_r <= 1'b0;
      need_pend_r   <= 1'b0;
    end else begin
      notice_pend_r <= param_change_notice | (notice_pend_r & ~issue_notic);
      need_pend_r   <= rx_reconfig_need | (need_pend_r & ~issue_need);
    end
  end

  // Strobe and busy flag; the confirm paces the next request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_req_r   <= 1'b0;
      ctl_busy_r  <= 1'b0;
      ctl_cause_r <= 2'(lms_pkg::LMS_CAUSE_NONE);
    end else begin
      ctl_req_r  <= ctl_issue;
      ctl_busy_r <= ctl_issue | (ctl_busy_r & ~far_param_change_xfer_cfm);
      if (ctl_issue) begin
        ctl_cause_r <= issue_notic ? 2'(lms_pkg::LMS_CAUSE_NOTICE)
                                   : 2'(lms_pkg::LMS_CAUSE_RX_NEED);
      end
    end
  end

endmodule

`default_nettype wire

// *** src/lms_defs.svh ***
// Constants for the line modulation sublayer handshake block.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef LMS_DEFS_SVH
`define LMS_DEFS_SVH

// -----------------------------------------------------------------
// Widths
// -----------------------------------------------------------------
`define LMS_FRAME_W        16
`define LMS_LEN_W          11
`define LMS_KIND_W         2
`define LMS_POS_W          7

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define LMS_CLK_HZ         50000000
`define LMS_SYM_RATE_HZ    4000
`define LMS_SYM_CYCLES     (`LMS_CLK_HZ / `LMS_SYM_RATE_HZ)
`define LMS_SF_DATA_SYMS   68

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define LMS_LEN_RST        11'h0F0

`endif

// *** src/lms_pkg.sv ***
// Types shared by the line modulation sublayer handshake block.
// Assumes nothing of its surroundings.
package lms_pkg;

  // -----------------------------------------------------------------
  // Symbol kinds on the line stream
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    LMS_KIND_DATA,
    LMS_KIND_FLAG,
    LMS_KIND_SYNC
  } lms_kind_t;

  // -----------------------------------------------------------------
  // Transmit sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    LMS_TX_IDLE,
    LMS_TX_REQ,
    LMS_TX_WAIT,
    LMS_TX_SYNC
  } lms_tx_state_t;

  // -----------------------------------------------------------------
  // Control request causes
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    LMS_CAUSE_NONE,
    LMS_CAUSE_NOTICE,
    LMS_CAUSE_RX_NEED
  } lms_cause_t;

endpackage

// *** src/lms_pair_buf.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module lms_pair_buf #(
  parameter int W = 18
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // Occupancy
  output logic [1:0]        count
);

  // -----------------------------------------------------------------
  // Storage and pointers
  // -----------------------------------------------------------------
  logic [W-1:0] mem_r [0:1];
  logic         wr_idx_r;
  logic         rd_idx_r;
  logic [1:0]   cnt_r;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  // Honest flags: full only at two entries, so a stalled drain really fills it.
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rd_idx_r];
  assign count     = cnt_r;

  // Each entry loads when the write pointer selects it.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ent
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem_r[gi] <= '0;
        end else if (push && (wr_idx_r == 1'(gi))) begin
          mem_r[gi] <= in_data;
        end
      end
    end
  endgenerate

  // Pointers and occupancy move with push and pop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_idx_r <= 1'b0;
      rd_idx_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) wr_idx_r <= ~wr_idx_r;
      if (pop)  rd_idx_r <= ~rd_idx_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

// *** test/lms_line_sublayer_sva.sv ***
// Port checker for the line sublayer handshake block.
// Bound to lms_line_sublayer from the bench; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "lms_defs.svh"
module lms_line_sublayer_sva (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // Transmit side
  input wire logic                    symbol_data_xfer_req,
  input wire logic                    sync_flag_xfer_req,
  input wire logic                    sync_flag_xfer_cfm,
  input wire logic                    sync_flag_busy,
  input wire logic                    tx_sym_valid,
  input wire logic                    tx_sym_ready,
  input wire logic [`LMS_FRAME_W-1:0] tx_sym_data,
  input wire logic [`LMS_KIND_W-1:0]  tx_sym_kind,
  input wire logic [`LMS_POS_W-1:0]   superframe_pos,
  // Receive side
  input wire logic                    rx_sym_valid,
  input wire logic [`LMS_KIND_W-1:0]  rx_sym_kind,
  input wire logic [`LMS_FRAME_W-1:0] rx_sym_data,
  input wire logic                    symbol_data_xfer_ind,
  input wire logic [`LMS_FRAME_W-1:0] symbol_data_xfer_ind_bits,
  input wire logic                    sync_flag_xfer_ind,
  // Control
  input wire logic                    param_change_notice,
  input wire logic                    far_param_change_xfer_req,
  input wire logic [1:0]              far_param_change_xfer_cause
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rx_data; rx_sym_valid && rx_sym_kind == 2'h0; endsequence
  sequence s_rx_flag; rx_sym_valid && rx_sym_kind == 2'h1; endsequence
  sequence s_flag_pop; tx_sym_valid && tx_sym_ready && tx_sym_kind == 2'h1; endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_REQ_PULSE: assert property (symbol_data_xfer_req |=> !symbol_data_xfer_req)
    else $error("frame request wider than one cycle");
  AST_IND_DATA: assert property (s_rx_data |=> symbol_data_xfer_ind &&
    symbol_data_xfer_ind_bits == $past(rx_sym_data)) else $error("data indication wrong");
  AST_IND_CAUSE: assert property (symbol_data_xfer_ind |->
    $past(rx_sym_valid) && $past(rx_sym_kind) == 2'h0) else $error("stray data indication");
  AST_FLAG_IND: assert property (s_rx_flag |=> sync_flag_xfer_ind &&
    !symbol_data_xfer_ind) else $error("flag indication missing");
  AST_FLAG_CFM: assert property (s_flag_pop |=> sync_flag_xfer_cfm)
    else $error("flag confirm missing after flag left");
  AST_CFM_CAUSE: assert property (sync_flag_xfer_cfm |-> $past(tx_sym_valid) &&
    $past(tx_sym_ready) && $past(tx_sym_kind) == 2'h1) else $error("early flag confirm");
  AST_BUSY: assert property (sync_flag_xfer_req |=> sync_flag_busy)
    else $error("flag request not taken");
  AST_HOLD: assert property (tx_sym_valid && !tx_sym_ready |=> tx_sym_valid &&
    $stable(tx_sym_data) && $stable(tx_sym_kind)) else $error("stalled word changed");
  AST_POS: assert property (superframe_pos <= 7'd67)
    else $error("superframe position out of range");
  AST_NOTICE: assert property (param_change_notice |-> ##[1:30]
    far_param_change_xfer_req && far_param_change_xfer_cause == 2'h1)
    else $error("notice not followed by control request");
  AST_CTRL_PULSE: assert property (far_param_change_xfer_req |=>
    !far_param_change_xfer_req) else $error("control request too wide");
  AST_CAUSE: assert property (!far_param_change_xfer_req |->
    $stable(far_param_change_xfer_cause)) else $error("cause moved without request");
endmodule
`default_nettype wire

// *** test/lms_framer_model.sv ***
// Transmit framing sublayer model: confirms each frame request.
// Assumes the design's clock; payload counts up from 1000h.
`timescale 1ns/1ps
`default_nettype none
`include "lms_defs.svh"
module lms_framer_model #(
  parameter int DLY = 2
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Frame handshake
  input  wire logic                    req,
  output logic                         cfm,
  output logic [`LMS_FRAME_W-1:0]      bits
);
  // ----------------------------------------------------------------
  // Confirm sequencer
  // ----------------------------------------------------------------
  logic [`LMS_FRAME_W-1:0] nxt_r;
  int                      wait_r;
  // One confirm per request, in order; bits are scrambled outside it.
  always_ff @(posedge clk) begin
    cfm <= 1'b0;
    bits <= ~bits;
    if (!rst_n) begin
      nxt_r  <= 16'h1000;
      wait_r <= 0;
      bits   <= 16'h0000;
    end else if (req) begin
      wait_r <= DLY;
    end else if (wait_r == 1) begin
      wait_r <= 0;
      cfm    <= 1'b1;
      bits   <= nxt_r;
      nxt_r  <= nxt_r + 16'h0001;
    end else if (wait_r != 0) begin
      wait_r <= wait_r - 1;
    end
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the line sublayer handshake block.
// Assumes the framing model file and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "lms_defs.svh"
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int SYM = 20;
  typedef struct packed {logic v; logic [1:0] k; logic [15:0] d; logic ei; logic ef;} lms_row_t;
  logic clk, rst_n, symbol_data_xfer_req, symbol_data_xfer_cfm, sync_flag_xfer_req;
  logic sync_flag_xfer_cfm, tx_sym_valid, tx_sym_ready, rx_sym_valid, symbol_data_xfer_ind;
  logic sync_flag_xfer_ind, param_change_notice, rx_reconfig_need, far_param_change_xfer_req;
  logic far_param_change_xfer_cfm, far_param_change_xfer_ind, sync_flag_busy, stall, gap_on;
  logic [`LMS_FRAME_W-1:0] symbol_data_xfer_bits, tx_sym_data, rx_sym_data;
  logic [`LMS_FRAME_W-1:0] symbol_data_xfer_ind_bits, exp_d;
  logic [`LMS_LEN_W-1:0]   symbol_data_xfer_len, far_param_change_xfer_len;
  logic [1:0]              tx_sym_kind, rx_sym_kind, far_param_change_xfer_cause;
  logic [`LMS_POS_W-1:0]   superframe_pos;
  int err_total, tests_run, cyc, last_req, n_data, n_sync, n_flag, n_req, n, f0;
  lms_row_t rows [6] = '{'{1'b1, 2'h0, 16'hA5A5, 1'b1, 1'b0}, '{1'b1, 2'h1, 16'h0000, 1'b0, 1'b1},
    '{1'b1, 2'h0, 16'h5A5A, 1'b1, 1'b0}, '{1'b1, 2'h2, 16'h1234, 1'b0, 1'b0},
    '{1'b1, 2'h3, 16'hFFFF, 1'b0, 1'b0}, '{1'b0, 2'h0, 16'h0001, 1'b0, 1'b0}};

  lms_line_sublayer #(.SYM_CYCLES(SYM)) dut (.clk, .rst_n, .symbol_data_xfer_req,
    .symbol_data_xfer_cfm, .symbol_data_xfer_bits, .symbol_data_xfer_len, .sync_flag_xfer_req,
    .sync_flag_xfer_cfm, .tx_sym_valid, .tx_sym_ready, .tx_sym_data, .tx_sym_kind,
    .rx_sym_valid, .rx_sym_kind, .rx_sym_data, .symbol_data_xfer_ind,
    .symbol_data_xfer_ind_bits, .sync_flag_xfer_ind, .param_change_notice, .rx_reconfig_need,
    .far_param_change_xfer_req, .far_param_change_xfer_cause, .far_param_change_xfer_cfm,
    .far_param_change_xfer_ind, .far_param_change_xfer_len, .superframe_pos, .sync_flag_busy);
  lms_framer_model #(.DLY(2)) u_frm (.clk, .rst_n, .req(symbol_data_xfer_req),
    .cfm(symbol_data_xfer_cfm), .bits(symbol_data_xfer_bits));

  // ----------------------------------------------------------------
  // Clock, line acceptor and stream monitor
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // The line stalls one cycle in four, or fully while stall is set.
  always @(posedge clk) begin
    #1;
    cyc++;
    tx_sym_ready = !stall && (cyc[1:0] != 2'h3);
  end
  // Sampled at the falling edge, where every output has settled.
  always @(negedge clk) begin
    if (rst_n && tx_sym_valid && tx_sym_ready) begin
      if (tx_sym_kind == 2'h0) begin
        chk(tx_sym_data, exp_d);
        exp_d++;
        n_data++;
      end else if (tx_sym_kind == 2'h2) begin
        chk(16'(n_data % 68), 16'h0000);
        n_sync++;
      end else begin
        n_flag++;
      end
    end
    if (rst_n && symbol_data_xfer_req) begin
      if (gap_on && last_req >= 0) chk(16'(cyc - last_req), 16'(SYM));
      last_req = cyc;
      n_req++;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(); @(posedge clk); #1; endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Resets for 16 cycles and checks the idle state before release.
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) tick();
    chk(16'(symbol_data_xfer_len), 16'(`LMS_LEN_RST));
    chk(16'(superframe_pos), 16'h0000);
    chk({tx_sym_valid, symbol_data_xfer_req, far_param_change_xfer_req}, 16'h0000);
    exp_d = 16'h1000;
    n_data = 0;
    last_req = -1;
    rst_n = 1'b1;
  endtask
  // Waits for a control request, checks its cause, then confirms it.
  task automatic ctrl_wait(input logic [1:0] c);
    n = 0;
    while (far_param_change_xfer_req !== 1'b1 && n < 40) begin tick(); n++; end
    chk(16'(far_param_change_xfer_req), 16'h0001);
    chk(16'(far_param_change_xfer_cause), 16'(c));
    tick();
    far_param_change_xfer_cfm = 1'b1;
    tick();
    far_param_change_xfer_cfm = 1'b0;
  endtask
  task automatic stop_test();
    $display("Counts: tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {sync_flag_xfer_req, rx_sym_valid, rx_sym_kind, rx_sym_data, param_change_notice} = '0;
    {rx_reconfig_need, far_param_change_xfer_cfm, far_param_change_xfer_ind} = '0;
    {stall, tx_sym_ready, far_param_change_xfer_len, err_total, tests_run, cyc} = '0;
    {n_sync, n_flag, n_req} = '0;
    gap_on = 1'b1;
    do_reset();
    foreach (rows[i]) begin
      {rx_sym_valid, rx_sym_kind, rx_sym_data} = {rows[i].v, rows[i].k, rows[i].d};
      tick();
      chk({symbol_data_xfer_ind, sync_flag_xfer_ind}, {rows[i].ei, rows[i].ef});
      if (rows[i].ei) chk(symbol_data_xfer_ind_bits, rows[i].d);
    end
    rx_sym_valid = 1'b0;
    param_change_notice = 1'b1;
    tick();
    param_change_notice = 1'b0;
    ctrl_wait(2'h1);
    rx_reconfig_need = 1'b1;
    tick();
    rx_reconfig_need = 1'b0;
    ctrl_wait(2'h2);
    {param_change_notice, rx_reconfig_need} = 2'b11;
    tick();
    {param_change_notice, rx_reconfig_need} = 2'b00;
    ctrl_wait(2'h1);
    ctrl_wait(2'h2);
    far_param_change_xfer_len = 11'h123;
    far_param_change_xfer_ind = 1'b1;
    tick();
    far_param_change_xfer_ind = 1'b0;
    repeat (SYM + 2) tick();
    chk(16'(symbol_data_xfer_len), 16'h0123);
    // Full stall with a flag pending: the buffer fills and requests stop.
    gap_on = 1'b0;
    stall = 1'b1;
    sync_flag_xfer_req = 1'b1;
    tick();
    sync_flag_xfer_req = 1'b0;
    f0 = n_flag;
    repeat (60) tick();
    n = n_req;
    repeat (60) tick();
    chk(16'(n_req - n), 16'h0000);
    chk(16'(sync_flag_busy), 16'h0001);
    stall = 1'b0;
    n = 0;
    while (sync_flag_xfer_cfm !== 1'b1 && n < 100) begin tick(); n++; end
    chk(16'(n_flag - f0), 16'h0001);
    chk(16'(sync_flag_busy), 16'h0000);
    repeat (3 * SYM) tick();
    last_req = -1;
    gap_on = 1'b1;
    n = 0;
    while (n_sync < 1 && n < 3000) begin tick(); n++; end
    chk(16'(n_sync), 16'h0001);
    do_reset();
    // The first tick lands SYM cycles after release; the margin lets the third frame drain.
    repeat (3 * SYM + 10) tick();
    chk(16'(exp_d), 16'h1003);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule
bind lms_line_sublayer lms_line_sublayer_sva u_sva (.clk, .rst_n, .symbol_data_xfer_req,
  .sync_flag_xfer_req, .sync_flag_xfer_cfm, .sync_flag_busy, .tx_sym_valid, .tx_sym_ready,
  .tx_sym_data, .tx_sym_kind, .superframe_pos, .rx_sym_valid, .rx_sym_kind, .rx_sym_data,
  .symbol_data_xfer_ind, .symbol_data_xfer_ind_bits, .sync_flag_xfer_ind,
  .param_change_notice, .far_param_change_xfer_req, .far_param_change_xfer_cause);
`default_nettype wire
